/* File: verilog/crs_reset_seq.sv */
`timescale 1ns/1ps
module crs_reset_seq
  import crs_pkg::*;
#(
  parameter int MIN_LOW = CRS_MIN_LOW_STATES
)
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        rst_in_n,
  input  wire logic [7:0]  mem_rdata,
  output logic      [23:0] mem_addr_q,
  output logic             mem_rd_q,
  output logic      [23:0] pc_q,
  output logic      [31:0] sp_q,
  output logic      [2:0]  imask_q,
  output logic             max_mode_q,
  output logic      [2:0]  bank_q,
  output logic             cpu_hold_q,
  output logic             cpu_start_q,
  output logic             io_init_q,
  output logic             port_gp_q,
  output logic             ale_oe_n_q,
  output logic             rst_accepted_q
);
  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= rst_in_n;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // low-state counter
  // ---------------------------------------------------------------
  // a glitch shorter than the minimum count never resets the cpu
  logic [CRS_CNT_W-1:0] cnt_q;
  logic [CRS_CNT_W-1:0] cnt_d;
  wire logic low_w  = ~sync2_q;
  wire logic done_w = (cnt_q >= CRS_CNT_W'(MIN_LOW));
  assign cnt_d = !low_w ? '0 : (done_w ? cnt_q : cnt_q + CRS_CNT_W'(1));
  always_ff @(posedge core_clk) begin
    if (sys_rst) cnt_q <= '0;
    else         cnt_q <= cnt_d;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  crs_state_t st_q;
  crs_state_t st_d;
  logic [1:0] vsel_q;
  logic [1:0] vsel_d;
  logic       fetch_w;
  logic       take_w;
  logic       mem_rd_dq;
  logic [1:0] tsel_q;
  always_comb begin
    st_d   = st_q;
    vsel_d = vsel_q;
    case (st_q)
      CRS_IDLE, CRS_RUN: begin
        vsel_d = CRS_VSEL_0;
        if (done_w) st_d = CRS_HOLD;
      end
      CRS_HOLD: begin
        st_d = CRS_FETCH;
      end
      CRS_FETCH: begin
        if (vsel_q == CRS_VSEL_W) st_d = CRS_WAIT_REL;
        else vsel_d = vsel_q + 2'h1;
      end
      CRS_WAIT_REL: begin
        if (!low_w) st_d = CRS_RUN;
      end
      default: st_d = CRS_IDLE;
    endcase
  end
  assign fetch_w = (st_q == CRS_FETCH) && (vsel_q != CRS_VSEL_W);
  // byte data stands the cycle after its strobe; the last byte lands after fetch has ended
  assign take_w  = mem_rd_dq;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q      <= CRS_IDLE;
      vsel_q    <= CRS_VSEL_0;
      mem_rd_dq <= 1'b0;
      tsel_q    <= CRS_VSEL_0;
    end else begin
      st_q      <= st_d;
      vsel_q    <= vsel_d;
      mem_rd_dq <= mem_rd_q;
      tsel_q    <= mem_rd_q ? mem_addr_q[1:0] : tsel_q;
    end
  end

  crs_vec_fetch u_fetch (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .sel        (vsel_q),
    .sel_vld    (fetch_w),
    .mem_addr_q (mem_addr_q),
    .mem_rd_q   (mem_rd_q)
  );

  // ---------------------------------------------------------------
  // cpu state presets
  // ---------------------------------------------------------------
  // data for a read issued at edge n arrives at edge n+1 and is sampled at edge n+2
  wire logic accept_w = (st_q == CRS_HOLD);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_q       <= '0;
      sp_q       <= CRS_SP_RESET;
      imask_q    <= CRS_IMASK_RESET;
      max_mode_q <= CRS_MAX_RESET;
      bank_q     <= CRS_BANK_RESET;
    end else begin
      if (accept_w) begin
        sp_q       <= CRS_SP_RESET;
        imask_q    <= CRS_IMASK_RESET;
        max_mode_q <= CRS_MAX_RESET;
        bank_q     <= CRS_BANK_RESET;
      end
      if (take_w) begin
        case (tsel_q)
          CRS_VSEL_0: pc_q[7:0]   <= mem_rdata;
          CRS_VSEL_1: pc_q[15:8]  <= mem_rdata;
          default:    pc_q[23:16] <= mem_rdata;
        endcase
      end
    end
  end
  // only these fields are touched; all other cpu state lives outside and is kept

  // ---------------------------------------------------------------
  // pin and peripheral controls
  // ---------------------------------------------------------------
  wire logic in_rst_w = (st_d == CRS_HOLD) || (st_d == CRS_FETCH) || (st_d == CRS_WAIT_REL);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpu_hold_q     <= 1'b1;
      cpu_start_q    <= 1'b0;
      io_init_q      <= 1'b1;
      port_gp_q      <= 1'b1;
      ale_oe_n_q     <= 1'b1;
      rst_accepted_q <= 1'b0;
    end else begin
      cpu_hold_q     <= in_rst_w || (st_d == CRS_IDLE);
      cpu_start_q    <= (st_q == CRS_WAIT_REL) && (st_d == CRS_RUN);
      io_init_q      <= in_rst_w;
      port_gp_q      <= in_rst_w;
      ale_oe_n_q     <= in_rst_w || (st_d == CRS_IDLE);
      rst_accepted_q <= in_rst_w;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_accept_after_low: assert property ((st_q == CRS_IDLE || st_q == CRS_RUN) && done_w |=> st_q == CRS_HOLD)
    else $error("reset not accepted after low count");
  a_no_early_accept: assert property (!done_w && st_q == CRS_RUN |=> st_q != CRS_HOLD)
    else $error("reset accepted too early");
  a_sp_preset: assert property (accept_w |=> sp_q == CRS_SP_RESET)
    else $error("stack pointer not preset");
  a_imask_preset: assert property (accept_w |=> imask_q == CRS_IMASK_RESET)
    else $error("interrupt mask not preset");
  a_max_preset: assert property (accept_w |=> max_mode_q)
    else $error("addressing mode not preset");
  a_bank_clear: assert property (accept_w |=> bank_q == CRS_BANK_RESET)
    else $error("register bank not cleared");
  a_pc_low_byte: assert property (take_w && tsel_q == CRS_VSEL_0 |=> pc_q[7:0] == $past(mem_rdata))
    else $error("pc low byte wrong");
  a_start_release: assert property (st_q == CRS_WAIT_REL && !low_w |=> cpu_start_q ##1 !cpu_start_q)
    else $error("start pulse wrong");
  a_ale_float: assert property (st_q == CRS_FETCH |-> ale_oe_n_q && port_gp_q && io_init_q)
    else $error("pins not in reset state");
  a_sp_stable: assert property (st_q == CRS_RUN && !done_w |=> $stable(sp_q))
    else $error("stack pointer changed outside reset");

  c_accept: cover property (accept_w);
  c_full_seq: cover property (st_q == CRS_WAIT_REL ##[1:50] cpu_start_q);
  c_glitch: cover property (low_w ##1 !low_w && st_q == CRS_RUN);
endmodule

/* File: verilog/crs_pkg.sv */
package crs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CRS_CLK_MHZ         = 50;
  localparam int CRS_MIN_LOW_STATES  = 10;
  localparam int CRS_CNT_W           = 4;
  // ---------------------------------------------------------------
  // vector and presets
  // ---------------------------------------------------------------
  localparam logic [23:0] CRS_VEC_ADDR0   = 24'hFFFF00;
  localparam logic [23:0] CRS_VEC_ADDR1   = 24'hFFFF01;
  localparam logic [23:0] CRS_VEC_ADDR2   = 24'hFFFF02;
  localparam logic [31:0] CRS_SP_RESET    = 32'h00000100;
  localparam logic [2:0]  CRS_IMASK_RESET = 3'h7;
  localparam logic        CRS_MAX_RESET   = 1'h1;
  localparam logic [2:0]  CRS_BANK_RESET  = 3'h0;
  localparam logic [1:0]  CRS_VSEL_0      = 2'h0;
  localparam logic [1:0]  CRS_VSEL_1      = 2'h1;
  localparam logic [1:0]  CRS_VSEL_2      = 2'h2;
  localparam logic [1:0]  CRS_VSEL_W      = 2'h3;
  typedef enum logic [2:0] {CRS_IDLE, CRS_HOLD, CRS_FETCH, CRS_WAIT_REL, CRS_RUN} crs_state_t;
endpackage

/* File: verilog/crs_vec_rom_if.sv */
`timescale 1ns/1ps
// registered byte fetch from the vector area; one-cycle read latency
module crs_vec_fetch
  import crs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  sel,
  input  wire logic        sel_vld,
  output logic      [23:0] mem_addr_q,
  output logic             mem_rd_q
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic [23:0] addr_w = (sel == CRS_VSEL_0) ? CRS_VEC_ADDR0 :
                             (sel == CRS_VSEL_1) ? CRS_VEC_ADDR1 : CRS_VEC_ADDR2;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_addr_q <= CRS_VEC_ADDR0;
      mem_rd_q   <= 1'b0;
    end else begin
      mem_addr_q <= addr_w;
      mem_rd_q   <= sel_vld;
    end
  end
endmodule

/* File: bench/crs_ext_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far side: external reset source and vector memory
// ---------------------------------------------------------------
module crs_ext_model (
  input  wire logic        core_clk,
  input  wire logic [23:0] vec,
  input  wire logic [23:0] mem_addr_q,
  input  wire logic        mem_rd_q,
  output logic             rst_in_n,
  output logic      [7:0]  mem_rdata
);
  initial rst_in_n = 1'h1;
  initial mem_rdata = 8'h00;
  // caller starts this only once supply and oscillator have settled
  task automatic drive_low(input int n);
    @(posedge core_clk) rst_in_n <= 1'h0;
    repeat (n) @(posedge core_clk);
    rst_in_n <= 1'h1;
  endtask
  // byte answers one edge after the strobe; idle bus toggles so no stale byte passes
  always @(posedge core_clk) begin
    if (mem_rd_q) begin
      mem_rdata <= vec[8*mem_addr_q[1:0] +: 8];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import crs_pkg::*;
  logic        core_clk, sys_rst, rst_in_n, mem_rd_q, cpu_hold_q, cpu_start_q;
  logic        io_init_q, port_gp_q, ale_oe_n_q, rst_accepted_q, max_mode_q;
  logic [7:0]  mem_rdata;
  logic [23:0] mem_addr_q, pc_q, vec;
  logic [31:0] sp_q;
  logic [2:0]  imask_q, bank_q;
  int          mismatches = 0;
  int          samples_checked = 0;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  crs_reset_seq DUT (.core_clk, .sys_rst, .rst_in_n, .mem_rdata, .mem_addr_q, .mem_rd_q,
    .pc_q, .sp_q, .imask_q, .max_mode_q, .bank_q, .cpu_hold_q, .cpu_start_q, .io_init_q,
    .port_gp_q, .ale_oe_n_q, .rst_accepted_q);
  crs_ext_model ext (.core_clk, .vec, .mem_addr_q, .mem_rd_q, .rst_in_n, .mem_rdata);
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // which 0 waits for accept, 1 for the start pulse
  task automatic wait_on(input int which);
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      if (which == 0 && rst_accepted_q === 1'h1) return;
      if (which == 1 && cpu_start_q === 1'h1) return;
    end
    mismatches++;
    $display("[FAIL] wait_%0d expected 1 seen 0", which);
    tally_and_finish();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_full(input logic [23:0] v, input int len);
    vec = v;
    fork
      ext.drive_low(len);
    join_none
    wait_on(0);
    chk("sp", 32'h00000100, sp_q);
    chk("imask", 32'h00000007, {29'h0, imask_q});
    chk("max_mode", 32'h00000001, {31'h0, max_mode_q});
    chk("bank", 32'h00000000, {29'h0, bank_q});
    chk("io_init", 32'h00000001, {31'h0, io_init_q});
    chk("port_gp", 32'h00000001, {31'h0, port_gp_q});
    chk("ale_oe_n", 32'h00000001, {31'h0, ale_oe_n_q});
    wait_on(1);
    chk("pc", {8'h00, v}, {8'h00, pc_q});
    chk("hold", 32'h00000000, {31'h0, cpu_hold_q});
    chk("max_kept", 32'h00000001, {31'h0, max_mode_q});
    @(posedge core_clk);
    #1;
    chk("start_pulse", 32'h00000000, {31'h0, cpu_start_q});
  endtask
  // a low pulse two states short of the minimum must be ignored
  task automatic t_short();
    fork
      ext.drive_low(CRS_MIN_LOW_STATES - 2);
    join_none
    repeat (30) @(posedge core_clk);
    #1;
    chk("short_accept", 32'h00000000, {31'h0, rst_accepted_q});
    chk("short_pc", 32'h00C3B2A1, {8'h00, pc_q});
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    vec = 24'h000000;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("idle_hold", 32'h00000001, {31'h0, cpu_hold_q});
    t_full(24'h5A3C81, CRS_MIN_LOW_STATES);
    t_full(24'hC3B2A1, 20);
    t_short();
    repeat (5) @(posedge core_clk);
    tally_and_finish();
  end
endmodule
